/* hdl/ticf_pkg.sv */
// ticf_pkg: constants and types of the timed input capture unit
// assumes one state time per clk cycle and AXI4-Lite register access
package ticf_pkg;
    localparam int NUM_PINS      = 4;
    localparam int TIMER_W       = 16;
    localparam int FIFO_DEPTH    = 7;
    localparam int ENTRY_W       = TIMER_W + NUM_PINS;
    localparam int ADDR_W        = 10;
    localparam int FULL_LEVEL    = 6;
    localparam int FOURTH_LEVEL  = 4;
    localparam int CLK_PERIOD_NS = 40;
    localparam int STATE_TIME_NS = 40;
    localparam int TICK_STATES   = 8;
    localparam int TICK_CYCLES   = TICK_STATES * STATE_TIME_NS / CLK_PERIOD_NS;
    localparam int EVERY8_COUNT  = 8;
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_EDGE_MODE  = 8'h03;
    localparam logic [7:0] IDX_TIME_TAG   = 8'h04;
    localparam logic [7:0] IDX_PIN_STATUS = 8'h06;
    localparam logic [7:0] IDX_TIMER      = 8'h0a;
    localparam logic [7:0] IDX_CTRL_ONE   = 8'h10;
    localparam logic [7:0] IDX_CTRL_TWO   = 8'h11;
    localparam logic [7:0] IDX_STATUS_TWO = 8'h12;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h13;
    localparam logic [7:0] IDX_MASK_HIGH  = 8'h14;
    localparam logic [7:0] IDX_WINDOW     = 8'h15;
    // per-pin edge modes
    localparam logic [1:0] MODE_EVERY8 = 2'h0;
    localparam logic [1:0] MODE_RISE   = 2'h1;
    localparam logic [1:0] MODE_FALL   = 2'h2;
    localparam logic [1:0] MODE_BOTH   = 2'h3;
    // field positions
    localparam int CTL2_SRC_SEL = 7;
    localparam int CTL2_OUT4_EN = 4;
    localparam int CTL2_OUT5_EN = 6;
    localparam int MASK_AVAIL   = 2;
    localparam int MASKH_FOURTH = 2;
    localparam int MASKH_FULL   = 6;
    localparam int WINDOW_ALT   = 0;
    // all registers reset to zero
    localparam logic [7:0] RST_VALUE = 8'h00;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_WRESP = 3'b010,
        BUS_RRESP = 3'b100
    } ticf_bus_e;
endpackage : ticf_pkg

/* hdl/ticf_fifo_if.sv */
// ticf_fifo_if: push and pop handshakes of the event fifo
// assumes one clock shared by both sides
`timescale 1ns/10ps
interface ticf_fifo_if #(
    parameter int W  = 20,
    parameter int CW = 3
);
    logic          push_valid;
    logic          push_ready;
    logic [W-1:0]  push_data;
    logic          pop_valid;
    logic          pop_ready;
    logic [W-1:0]  pop_data;
    logic [CW-1:0] count;
    modport fill  (output push_valid, push_data, pop_ready,
                   input push_ready, pop_valid, pop_data, count);
    modport store (input push_valid, push_data, pop_ready,
                   output push_ready, pop_valid, pop_data, count);
endinterface : ticf_fifo_if

/* hdl/ticf_fifo.sv */
// ticf_fifo: flip-flop fifo of time-tag entries
// assumes the filler honours push_ready; a push may join a pop when full
`timescale 1ns/10ps
module ticf_fifo
    import ticf_pkg::*;
#(
    parameter int W     = ENTRY_W,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int CW    = 3
)(
    input  wire logic  clk,
    input  wire logic  rst_n,
    ticf_fifo_if.store f
);
    localparam int PW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
    } ticf_fifo_s;
    ticf_fifo_s s;
    ticf_fifo_s next_s;
    logic       push;
    logic       pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : bump

    always_comb begin
        f.pop_valid  = (s.cnt != '0);
        f.pop_data   = s.mem[s.rp];
        f.count      = s.cnt;
        pop          = f.pop_valid && f.pop_ready;
        f.push_ready = (s.cnt != CW'(DEPTH)) || pop;
        push         = f.push_valid && f.push_ready;
        next_s       = s;
        if (push) begin
            next_s.mem[s.wp] = f.push_data;
            next_s.wp        = bump(s.wp);
        end
        if (pop) begin
            next_s.rp = bump(s.rp);
        end
        next_s.cnt = s.cnt + CW'(push) - CW'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : ticf_fifo

/* hdl/ticf_edge.sv */
// ticf_edge: edge selection for one input pin
// assumes level is already sampled once per state time
`timescale 1ns/10ps
module ticf_edge
    import ticf_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       level,
    input  wire logic [1:0] mode,
    output logic            event_p
);
    localparam int CNT_W = $clog2(EVERY8_COUNT);
    typedef struct packed {
        logic             prev;
        logic [CNT_W-1:0] cnt;
    } ticf_edge_s;
    ticf_edge_s s;
    ticf_edge_s next_s;
    logic       rise;
    logic       fall;

    always_comb begin
        next_s      = s;
        next_s.prev = level;
        rise        = level && !s.prev;
        fall        = !level && s.prev;
        event_p     = 1'b0;
        case (mode)
            MODE_EVERY8: begin
                // one rising edge counted per state time, event on wrap
                if (rise) begin
                    next_s.cnt = s.cnt + 1'b1;
                    event_p    = (s.cnt == CNT_W'(EVERY8_COUNT - 1));
                end
            end
            MODE_RISE: event_p = rise;
            MODE_FALL: event_p = fall;
            default:   event_p = rise || fall;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule : ticf_edge

/* hdl/ticf_unit.sv */
// ticf_unit: timed input capture unit with AXI4-Lite registers
// assumes pins synchronous to clk, one clk cycle per state time
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
module ticf_unit
    import ticf_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
)(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [ADDR_W-1:0]   awaddr,
    input  wire logic                awvalid,
    output logic                     awready,
    input  wire logic [31:0]         wdata,
    input  wire logic [3:0]          wstrb,
    input  wire logic                wvalid,
    output logic                     wready,
    output logic [1:0]               bresp,
    output logic                     bvalid,
    input  wire logic                bready,
    input  wire logic [ADDR_W-1:0]   araddr,
    input  wire logic                arvalid,
    output logic                     arready,
    output logic [31:0]              rdata,
    output logic [1:0]               rresp,
    output logic                     rvalid,
    input  wire logic                rready,
    input  wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0]      pin_out,
    output logic [NUM_PINS-1:0]      pin_oe,
    input  wire logic [1:0]          timed_out_level,
    output logic                     data_available_irq,
    output logic                     fifo_full_irq,
    output logic                     fourth_entry_irq,
    output logic                     pin0_irq
);
    localparam int CW     = $clog2(DEPTH + 1);
    localparam int TICK_W = $clog2(TICK_CYCLES);

    typedef struct packed {
        ticf_bus_e           bus;
        logic [TIMER_W-1:0]  timer;
        logic [TICK_W-1:0]   pre;
        logic [NUM_PINS-1:0] level;
        logic [NUM_PINS-1:0] pend;
        logic [7:0]          mode;
        logic [7:0]          ctl_one;
        logic [7:0]          ctl_two;
        logic [7:0]          mask;
        logic [7:0]          mask_high;
        logic                window;
        logic [5:0]          sts2_low;
        logic                hold_valid;
        logic [TIMER_W-1:0]  hold_time;
        logic [NUM_PINS-1:0] hold_mask;
        logic                prev_full;
        logic                prev_fourth;
        logic [3:0]          irq;
        logic [1:0]          out_level;
        logic [31:0]         rdata;
        logic [1:0]          resp;
    } ticf_state_s;

    ticf_state_s         s;
    ticf_state_s         next_s;
    logic [NUM_PINS-1:0] ev;
    logic [NUM_PINS-1:0] ev_en;
    logic [7:0]          widx;
    logic [7:0]          ridx;
    logic                wr_go;
    logic                rd_go;
    logic                rd_tag;
    logic                tag_wr;
    logic                tick;
    logic                load_ev;
    logic                full;
    logic                fourth;
    logic                full_rise;
    logic [7:0]          sts;

    ticf_fifo_if #(.W(ENTRY_W), .CW(CW)) fq ();

    ticf_fifo #(
        .W     (ENTRY_W),
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_fifo (
        .clk   (clk),
        .rst_n (rst_n),
        .f     (fq.store)
    );

    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        ticf_edge u_edge (
            .clk     (clk),
            .rst_n   (rst_n),
            .level   (s.level[i]),
            .mode    (s.mode[2*i +: 2]),
            .event_p (ev[i])
        );
    end

    function automatic logic known(input logic [7:0] idx);
        return (idx == IDX_EDGE_MODE) || (idx == IDX_TIME_TAG) ||
               (idx == IDX_PIN_STATUS) || (idx == IDX_TIMER) ||
               (idx == IDX_CTRL_ONE) || (idx == IDX_CTRL_TWO) ||
               (idx == IDX_STATUS_TWO) || (idx == IDX_IRQ_MASK) ||
               (idx == IDX_MASK_HIGH) || (idx == IDX_WINDOW);
    endfunction : known

    function automatic logic [7:0] wr8(input logic [7:0] old,
                                       input logic [7:0] d,
                                       input logic       en);
        return en ? d : old;
    endfunction : wr8

    function automatic logic [31:0] win8(input logic       alt,
                                         input logic [7:0] v);
        return alt ? {24'h0, v} : 32'h0;
    endfunction : win8

    always_comb begin
        wr_go   = (s.bus == BUS_IDLE) && awvalid && wvalid;
        rd_go   = (s.bus == BUS_IDLE) && arvalid && !wr_go;
        widx    = awaddr[ADDR_W-1:2];
        ridx    = araddr[ADDR_W-1:2];
        rd_tag  = rd_go && (ridx == IDX_TIME_TAG);
        tag_wr  = wr_go && s.window && (widx == IDX_TIME_TAG);
        tick    = (s.pre == TICK_W'(TICK_CYCLES - 1));
        ev_en   = ev & s.ctl_one[NUM_PINS-1:0];
        // one entry per tick, pins of the tick merged into it
        fq.push_valid = tick && ((s.pend | ev_en) != '0);
        fq.push_data  = {s.timer, s.pend | ev_en};
        fq.pop_ready  = !s.hold_valid && !tag_wr;
        load_ev   = fq.pop_valid && fq.pop_ready;
        full      = (fq.count >= CW'(FULL_LEVEL));
        fourth    = (fq.count >= CW'(FOURTH_LEVEL));
        full_rise = full && !s.prev_full;
        for (int i = 0; i < NUM_PINS; i++) begin
            sts[2*i]   = s.hold_mask[i];
            sts[2*i+1] = s.level[i];
        end

        next_s           = s;
        next_s.level     = pin_in;
        next_s.out_level = timed_out_level;
        next_s.pre       = tick ? '0 : s.pre + 1'b1;
        if (tick) begin
            next_s.timer = s.timer + 1'b1;
            next_s.pend  = '0;
        end else begin
            next_s.pend  = s.pend | ev_en;
        end
        next_s.prev_full   = full;
        next_s.prev_fourth = fourth;

        // interrupt pulses on rising conditions
        next_s.irq[0] = s.mask[MASK_AVAIL] &&
                        (s.ctl_two[CTL2_SRC_SEL] ? full_rise : load_ev);
        next_s.irq[1] = s.mask_high[MASKH_FULL] && !s.ctl_two[CTL2_SRC_SEL] &&
                        full_rise;
        next_s.irq[2] = s.mask_high[MASKH_FOURTH] && fourth &&
                        !s.prev_fourth;
        next_s.irq[3] = pin_in[0] && !s.level[0];

        if (wr_go) begin
            next_s.bus  = BUS_WRESP;
            next_s.resp = known(widx) ? RESP_OKAY : RESP_SLVERR;
            if (widx == IDX_EDGE_MODE) begin
                next_s.mode = wr8(s.mode, wdata[7:0], wstrb[0]);
            end else if (widx == IDX_TIME_TAG) begin
                if (s.window) begin
                    next_s.hold_time[7:0]  = wr8(s.hold_time[7:0], wdata[7:0], wstrb[0]);
                    next_s.hold_time[15:8] = wr8(s.hold_time[15:8], wdata[15:8], wstrb[1]);
                    next_s.hold_valid      = 1'b1;
                    next_s.hold_mask       = '0;
                end
            end else if (widx == IDX_PIN_STATUS) begin
                if (s.window && wstrb[0]) begin
                    next_s.hold_mask = s.hold_mask |
                        {wdata[6], wdata[4], wdata[2], wdata[0]};
                end
            end else if (widx == IDX_CTRL_ONE) begin
                next_s.ctl_one = wr8(s.ctl_one, wdata[7:0], wstrb[0]);
            end else if (widx == IDX_CTRL_TWO) begin
                next_s.ctl_two = wr8(s.ctl_two, wdata[7:0], wstrb[0]);
            end else if (widx == IDX_STATUS_TWO) begin
                if (s.window && wstrb[0]) begin
                    next_s.sts2_low = s.sts2_low | wdata[5:0];
                end
            end else if (widx == IDX_IRQ_MASK) begin
                next_s.mask = wr8(s.mask, wdata[7:0], wstrb[0]);
            end else if (widx == IDX_MASK_HIGH) begin
                next_s.mask_high = wr8(s.mask_high, wdata[7:0], wstrb[0]);
            end else if (widx == IDX_WINDOW) begin
                if (wstrb[0]) begin
                    next_s.window = wdata[WINDOW_ALT];
                end
            end
        end

        if (rd_go) begin
            next_s.bus   = BUS_RRESP;
            next_s.resp  = known(ridx) ? RESP_OKAY : RESP_SLVERR;
            next_s.rdata = 32'h0;
            if (ridx == IDX_EDGE_MODE) begin
                next_s.rdata = win8(s.window, s.mode);
            end else if (ridx == IDX_TIME_TAG) begin
                next_s.rdata      = {16'h0, s.hold_time};
                next_s.hold_valid = 1'b0;
            end else if (ridx == IDX_PIN_STATUS) begin
                next_s.rdata = {24'h0, sts};
            end else if (ridx == IDX_TIMER) begin
                next_s.rdata = {16'h0, s.timer};
            end else if (ridx == IDX_CTRL_ONE) begin
                next_s.rdata = win8(s.window, s.ctl_one);
            end else if (ridx == IDX_CTRL_TWO) begin
                next_s.rdata = win8(s.window, s.ctl_two);
            end else if (ridx == IDX_STATUS_TWO) begin
                next_s.rdata    = {24'h0, s.hold_valid, full, s.sts2_low};
                next_s.sts2_low = '0;
            end else if (ridx == IDX_IRQ_MASK) begin
                next_s.rdata = {24'h0, s.mask};
            end else if (ridx == IDX_MASK_HIGH) begin
                next_s.rdata = {24'h0, s.mask_high};
            end else if (ridx == IDX_WINDOW) begin
                next_s.rdata = {31'h0, s.window};
            end
        end

        case (s.bus)
            BUS_WRESP: begin
                if (bready) begin
                    next_s.bus = BUS_IDLE;
                end
            end
            BUS_RRESP: begin
                if (rready) begin
                    next_s.bus = BUS_IDLE;
                end
            end
            default: begin
            end
        endcase

        // pop whenever the holding register is empty and no time-tag write is pending, so the next entry is not lost
        if (load_ev) begin
            next_s.hold_valid = 1'b1;
            next_s.hold_time  = fq.pop_data[ENTRY_W-1:NUM_PINS];
            next_s.hold_mask  = fq.pop_data[NUM_PINS-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s     <= '0;
            s.bus <= BUS_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign awready            = wr_go;
    assign wready             = wr_go;
    assign arready            = rd_go;
    assign bvalid             = (s.bus == BUS_WRESP);
    assign rvalid             = (s.bus == BUS_RRESP);
    assign bresp              = s.resp;
    assign rresp              = s.resp;
    assign rdata              = s.rdata;
    assign data_available_irq = s.irq[0];
    assign fifo_full_irq      = s.irq[1];
    assign fourth_entry_irq   = s.irq[2];
    assign pin0_irq           = s.irq[3];
    // pins two and three turn into timed outputs
    assign pin_out = {s.out_level, 2'b00};
    assign pin_oe  = {s.ctl_two[CTL2_OUT5_EN], s.ctl_two[CTL2_OUT4_EN], 2'b00};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    timer_tick_a: assert property (tick |=> s.timer == $past(s.timer) + 1'b1)
        else $error("timer missed its tick");
    entry_time_a: assert property (
        (fq.push_valid && fq.push_ready && fq.count == '0 && !s.hold_valid &&
         !s.window) |=> ##1 (s.hold_valid && s.hold_time == $past(s.timer, 2)))
        else $error("holding time differs from stamped timer");
    one_entry_a: assert property (fq.push_valid |=> !fq.push_valid [*7])
        else $error("more than one entry per tick");
    hold_move_a: assert property (
        (fq.count != '0 && !s.hold_valid && !s.window) |-> ##[1:8] s.hold_valid)
        else $error("entry did not reach holding register");
    discard_a: assert property (
        (s.hold_valid && fq.count == CW'(DEPTH) && !rd_tag) |=> fq.count == CW'(DEPTH))
        else $error("full store changed without a pop");
    mode_read_a: assert property (
        (rd_go && ridx == IDX_EDGE_MODE && s.window) |=> rdata[7:0] == $past(s.mode))
        else $error("mode readback wrong");
    pin_enable_a: assert property (
        fq.push_valid |-> (fq.push_data[NUM_PINS-1:0] & ~s.ctl_one[NUM_PINS-1:0]) == '0)
        else $error("disabled pin entered the fifo");
    sts_clear_a: assert property (
        (rd_go && ridx == IDX_STATUS_TWO) |=> s.sts2_low == '0)
        else $error("status two low bits not cleared");
    tag_pop_a: assert property ((rd_tag && fq.count == '0) |=> !s.hold_valid)
        else $error("time-tag read did not pop");
    avail_irq_a: assert property (
        (load_ev && !s.ctl_two[CTL2_SRC_SEL] && s.mask[MASK_AVAIL])
        |=> data_available_irq && s.hold_valid)
        else $error("data available pulse missing");
    full_irq_a: assert property (
        ($rose(full) && !s.ctl_two[CTL2_SRC_SEL] && s.mask_high[MASKH_FULL])
        |=> fifo_full_irq ##1 !fifo_full_irq)
        else $error("fifo full pulse wrong");
    full_route_a: assert property (s.ctl_two[CTL2_SRC_SEL] |=> !fifo_full_irq)
        else $error("full pulse not rerouted");
    fourth_irq_a: assert property (
        ($rose(fourth) && s.mask_high[MASKH_FOURTH]) |=> fourth_entry_irq)
        else $error("fourth entry pulse missing");
    pin0_irq_a: assert property ((pin_in[0] && !s.level[0]) |=> pin0_irq)
        else $error("pin zero pulse missing");
    irq_pulse_a: assert property (data_available_irq |=> !data_available_irq)
        else $error("data available held high");
endmodule : ticf_unit

/* bench/ticf_pins.sv */
// ticf_pins: far-side drivers of the four pins
// assumes targets set once per clk by the bench
`timescale 1ns/10ps
module ticf_pins (
    input  wire logic       clk,
    input  wire logic [3:0] target,
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    output logic      [3:0] pin_in
);
    logic [3:0] level;
    always_ff @(posedge clk) level <= target;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & level);
endmodule : ticf_pins

/* bench/ticf_unit_tb.sv */
// ticf_unit_tb: self-checking bench of the capture unit
// assumes ticf_pins as far side, AXI4-Lite master tasks
`timescale 1ns/10ps
module ticf_unit_tb
    import ticf_pkg::*;
;
    logic              clk, rst_n;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [31:0]       wdata, rdata, d, e;
    logic [3:0]        wstrb, target, pin_in, pin_out, pin_oe;
    logic [1:0]        bresp, rresp, timed_out_level, r;
    logic [15:0]       prev;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic data_available_irq, fifo_full_irq, fourth_entry_irq, pin0_irq;
    int   n_errors, checked, n_av, n_full, n_four, n_p0;
    ticf_unit dut (.clk, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .pin_in, .pin_out, .pin_oe, .timed_out_level,
        .data_available_irq, .fifo_full_irq, .fourth_entry_irq, .pin0_irq);
    ticf_pins far (.clk, .target, .pin_out, .pin_oe, .pin_in);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        n_av   <= n_av + data_available_irq;
        n_full <= n_full + fifo_full_irq;
        n_four <= n_four + fourth_entry_irq;
        n_p0   <= n_p0 + pin0_irq;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        @(posedge clk);
        awaddr  <= {idx, 2'h0};
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do @(posedge clk); while (awready !== 1'b1);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do @(posedge clk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] rr);
        @(posedge clk);
        araddr  <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        v  = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    function automatic logic [31:0] stat(input logic [3:0] ev, input logic [3:0] lv);
        stat = '0;
        for (int i = 0; i < NUM_PINS; i++) begin
            stat[2*i]   = ev[i];
            stat[2*i+1] = lv[i];
        end
    endfunction : stat
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    initial begin
        #(CLK_PERIOD_NS * 20000);
        n_errors++;
        end_sim();
    end
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, target} = '0;
        wstrb = 4'hf;
        void'($urandom(70054));
        timed_out_level = 2'($urandom);
        cyc(10);
        rst_n <= 1'b1;
        wr(IDX_WINDOW, 32'h1);
        chk(32'(r), 32'(RESP_OKAY));
        d = 32'($urandom % 256);
        wr(IDX_EDGE_MODE, d);
        rd(IDX_EDGE_MODE, e, r);
        chk(e, d);
        rd(8'hff, e, r);
        chk(32'(r), 32'(RESP_SLVERR));
        wr(8'hff, 32'h0);
        chk(32'(r), 32'(RESP_SLVERR));
        wr(IDX_STATUS_TWO, 32'h3f);
        rd(IDX_STATUS_TWO, e, r);
        rd(IDX_STATUS_TWO, d, r);
        chk(32'({e[5:0], d[5:0]}), 32'hfc0);
        wr(IDX_TIME_TAG, 32'h1234);
        wr(IDX_PIN_STATUS, 32'h1);
        rd(IDX_PIN_STATUS, e, r);
        chk(e, stat(4'h1, 4'h0));
        rd(IDX_TIME_TAG, e, r);
        chk(e, 32'h1234);
        wr(IDX_WINDOW, 32'h0);
        $display("done regs");
        wr(IDX_EDGE_MODE, 32'h55);
        wr(IDX_IRQ_MASK, 32'h4);
        wr(IDX_MASK_HIGH, 32'h44);
        wr(IDX_CTRL_ONE, 32'h7);
        @(posedge clk) target <= 4'hb;
        cyc(24);
        rd(IDX_PIN_STATUS, e, r);
        chk(e, stat(4'h3, 4'hb));
        chk(32'(n_p0 + 2 * n_av), 32'h3);
        rd(IDX_STATUS_TWO, e, r);
        chk(32'(e[7]), 32'h1);
        rd(IDX_TIME_TAG, e, r);
        cyc(8);
        rd(IDX_STATUS_TWO, e, r);
        chk(32'(e[7]), 32'h0);
        $display("done shared entry");
        wr(IDX_EDGE_MODE, 32'h57);
        wr(IDX_CTRL_ONE, 32'h1);
        for (int m = 0; m < 2; m++) begin
            wr(IDX_CTRL_TWO, 32'(m) << CTL2_SRC_SEL);
            for (int k = 0; k < 10; k++) begin
                @(posedge clk) target[0] <= ~target[0];
                cyc(15);
            end
            rd(IDX_STATUS_TWO, e, r);
            chk(32'(e[7:6]), 32'h3);
            for (int k = 0; k < 8; k++) begin
                rd(IDX_TIME_TAG, e, r);
                if (k > 0) chk(32'(e[15:0] - prev), 32'h2);
                prev = e[15:0];
                cyc(8);
            end
            rd(IDX_STATUS_TWO, e, r);
            chk(32'(e[7]), 32'h0);
        end
        chk(32'(n_full * 4 + n_four), 32'h6);
        chk(32'(n_av), 32'ha);
        $display("done fill");
        wr(IDX_EDGE_MODE, 32'h0);
        wr(IDX_CTRL_ONE, 32'h4);
        for (int k = 0; k < 8; k++) begin
            @(posedge clk) target[2] <= 1'b1;
            cyc(2);
            @(posedge clk) target[2] <= 1'b0;
            cyc(2);
            if (k == 6) rd(IDX_STATUS_TWO, d, r);
        end
        cyc(24);
        rd(IDX_STATUS_TWO, e, r);
        chk(32'({d[7], e[7]}), 32'h1);
        rd(IDX_TIME_TAG, e, r);
        wr(IDX_EDGE_MODE, 32'h20);
        @(posedge clk) target[2] <= 1'b1;
        cyc(24);
        rd(IDX_STATUS_TWO, d, r);
        @(posedge clk) target[2] <= 1'b0;
        cyc(24);
        rd(IDX_STATUS_TWO, e, r);
        chk(32'({d[7], e[7]}), 32'h1);
        wr(IDX_CTRL_TWO, 32'h10);
        cyc(3);
        chk(32'({pin_oe[2], pin_in[2]}), {30'h0, 1'b1, timed_out_level[0]});
        $display("done modes");
        end_sim();
    end
endmodule : ticf_unit_tb
